// ==== cmt_map.svh ====
/*
  constants for the configurable mode timer: mode codes, time limits and
  tick timing. assumes a 100 MHz system clock.
*/
`ifndef CMT_MAP_SVH
`define CMT_MAP_SVH

`define CMT_TYPE_OFF      3'h0
`define CMT_TYPE_PULSE    3'h1
`define CMT_TYPE_DELAY    3'h2
`define CMT_TYPE_SHOT     3'h3
`define CMT_TYPE_MINON    3'h4
`define CMT_MIN_MAX       10'h3e7
`define CMT_SEC_MAX       6'h3b
`define CMT_CLK_HZ        100000000
`define CMT_TICK_S        1
`define CMT_TICK_CYCLES   (`CMT_CLK_HZ * `CMT_TICK_S)
`define CMT_HALF          16'h8000

`endif

// ==== cmt_pkg.sv ====
/*
  types for the configurable mode timer.
  assumes cmt_map.svh is on the include path.
*/
package cmt_pkg;
  // minutes and seconds time value, 000:00 to 999:59
  typedef struct packed {
    logic [9:0] min;
    logic [5:0] sec;
  } cmt_time_t;

  typedef enum logic [2:0] {
    CMT_OFF   = 3'h0,
    CMT_PULSE = 3'h1,
    CMT_DELAY = 3'h2,
    CMT_SHOT  = 3'h3,
    CMT_MINON = 3'h4
  } cmt_type_t;

  // whole state of the timer
  typedef struct packed {
    logic [31:0] tick_cnt;
    logic        tick;
    logic        in_s1;
    logic        in_s2;
    logic        in_prev;
    logic        out;
    logic        trig;
    logic        shot_ld;
    cmt_time_t   dur;
    cmt_time_t   rem;
    cmt_time_t   elapsed;
  } cmt_state_t;
endpackage : cmt_pkg

// ==== cmt_timer.sv ====
/*
  configurable mode timer: off, on-pulse, on-delay, one-shot, minimum-on.
  assumes a free 100 MHz clock; trigger comes from a pin or another domain
  and is synchronised here. duration is written by a strobe.
*/
// Notes on behaviour
// - type selects off, pulse, delay, shot, minimum-on
// - times range 000:00 to 999:59
// - retrigger modes copy duration; pulse decrements the copy
// - elapsed time read-only, minutes and seconds
// - triggered flag shows timer is timing
// - pulse: output on at trigger until expiry
// - pulse: retrigger restarts period
// - delay: output after delay, until input drops
// - delay: early drop keeps output off
// - shot: count down per tick, clear at zero
// - shot: time editable any moment
// - shot: no reload, operator writes new time
// - shot: input gates count and output
// - shot: flag set on write, cleared with output
// - minimum-on: rising input sets output
// - minimum-on: falling input starts elapsed counting
// - minimum-on: output off when elapsed reaches duration
// - minimum-on: input high again zeroes elapsed
// - minimum-on: flag while elapsed above zero
// - numeric trigger at or above half is on
`include "cmt_map.svh"
module cmt_timer #(
  parameter int unsigned TICK_CYCLES = `CMT_TICK_CYCLES
) (
  // clock and reset
  input  wire logic              CLK_SYS,
  input  wire logic              RST_N,
  // configuration
  input  wire cmt_pkg::cmt_type_t TYPE_SEL,
  input  wire cmt_pkg::cmt_time_t TIME_WDATA,
  input  wire logic              TIME_WE,
  // trigger: digital bit or numeric 0.16 fraction
  input  wire logic              TRIG_IN,
  input  wire logic              TRIG_NUM_SEL,
  input  wire logic [15:0]       TRIG_NUM,
  // results
  output logic                   TIMER_OUT,
  output logic                   TRIGGERED_FLAG,
  output cmt_pkg::cmt_time_t     ELAPSED_TIME,
  output cmt_pkg::cmt_time_t     TIME_VALUE
);
  import cmt_pkg::*;

  cmt_state_t s_q;   // registered state
  cmt_state_t s_d;   // next state

  // clamp a written time into the legal range
  function automatic cmt_time_t clamp_t(input cmt_time_t t);
    cmt_time_t r;
    r = t;
    if (r.min > `CMT_MIN_MAX) r.min = `CMT_MIN_MAX;
    if (r.sec > `CMT_SEC_MAX) r.sec = `CMT_SEC_MAX;
    return r;
  endfunction

  // one second down, borrowing a minute at 0 seconds
  function automatic cmt_time_t dec_t(input cmt_time_t t);
    cmt_time_t r;
    r = t;
    if (t.sec != 6'h00) begin
      r.sec = t.sec - 6'h01;
    end else if (t.min != 10'h000) begin
      r.min = t.min - 10'h001;
      r.sec = `CMT_SEC_MAX;
    end
    return r;
  endfunction

  // one second up, carrying into minutes after 59, saturating at 999:59
  function automatic cmt_time_t inc_t(input cmt_time_t t);
    cmt_time_t r;
    r = t;
    if (t.sec != `CMT_SEC_MAX) begin
      r.sec = t.sec + 6'h01;
    end else if (t.min != `CMT_MIN_MAX) begin
      r.min = t.min + 10'h001;
      r.sec = 6'h00;
    end
    return r;
  endfunction

  // true when a time value has run down to 000:00
  // used by pulse, delay, shot and minimum-on, so it lives in one place
  function automatic logic is_zero(input cmt_time_t t);
    return (t.min == 10'h000) && (t.sec == 6'h00);
  endfunction

  // trigger level before synchronising; a numeric source is a threshold
  logic in_raw;
  assign in_raw = TRIG_NUM_SEL ? (TRIG_NUM >= `CMT_HALF) : TRIG_IN;

  // next-state logic for the whole block
  always_comb begin
    logic      in_now;  // synchronised trigger
    logic      rise;
    logic      fall;
    cmt_time_t wr;      // clamped write value
    s_d    = s_q;
    in_now = s_q.in_s2;
    rise   = in_now & ~s_q.in_prev;
    fall   = ~in_now & s_q.in_prev;
    wr     = clamp_t(TIME_WDATA);

    // two-stage synchroniser; only the second stage is used below
    s_d.in_s1   = in_raw;
    s_d.in_s2   = s_q.in_s1;
    s_d.in_prev = in_now;

    // one-second tick enable from the free clock
    if (s_q.tick_cnt >= TICK_CYCLES - 1) begin
      s_d.tick_cnt = 32'h0000_0000;
      s_d.tick     = 1'b1;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 32'h0000_0001;
      s_d.tick     = 1'b0;
    end

    // the duration register: the operator write always lands
    if (TIME_WE) begin
      s_d.dur = wr;
    end

    unique case (TYPE_SEL)
      CMT_PULSE: begin
        // a copy of the duration counts down and the duration stays; retrigger
        // reloads the last written value so the period starts over
        if (rise) begin
          s_d.out     = 1'b1;
          s_d.trig    = 1'b1;
          s_d.rem     = s_d.dur;
          s_d.elapsed = '0;
        end else if (s_q.out && s_q.tick) begin
          s_d.rem     = dec_t(s_q.rem);
          s_d.elapsed = inc_t(s_q.elapsed);
          if (is_zero(dec_t(s_q.rem))) begin
            s_d.out  = 1'b0;
            s_d.trig = 1'b0;
          end
        end
        if (is_zero(s_d.rem) && !rise) begin
          s_d.out  = 1'b0;
          s_d.trig = 1'b0;
        end
      end
      CMT_DELAY: begin
        // the delay is measured with the elapsed count against the
        // duration, so the remaining-time register can hold the
        // duration for display and the output stays a plain flop
        if (!in_now) begin
          s_d.out     = 1'b0;
          s_d.trig    = 1'b0;
          s_d.elapsed = '0;
        end else if (rise) begin
          s_d.rem     = s_d.dur;
          s_d.trig    = 1'b1;
          s_d.elapsed = '0;
          s_d.out     = is_zero(s_d.dur);
        end else if (s_q.trig && !s_q.out && s_q.tick) begin
          // one more second of valid input; a duration lowered during
          // the count is met at the next tick because the test is at-or-above
          s_d.elapsed = inc_t(s_q.elapsed);
          if (s_d.elapsed >= s_d.dur) s_d.out = 1'b1;
        end
      end
      CMT_SHOT: begin
        // the remaining time is the written value and is never reloaded
        if (TIME_WE) begin
          s_d.rem     = wr;
          s_d.shot_ld = 1'b1;
          s_d.elapsed = '0;
        end else if (in_now && s_q.tick && !is_zero(s_q.rem)) begin
          s_d.rem     = dec_t(s_q.rem);
          s_d.elapsed = inc_t(s_q.elapsed);
        end
        // gate: output on only while input set and time left
        s_d.out = in_now && !is_zero(s_d.rem);
        if (is_zero(s_d.rem)) s_d.shot_ld = 1'b0;
        // flag set by the write, dropped when the output goes off unless a write lands in the same cycle
        if (s_q.out && !s_d.out && !TIME_WE) s_d.shot_ld = 1'b0;
        s_d.trig = s_d.shot_ld;
      end
      CMT_MINON: begin
        if (rise) begin
          s_d.out     = 1'b1;
          s_d.elapsed = '0;
        end else if (in_now) begin
          s_d.elapsed = '0;
        end else if (s_q.out && s_q.tick) begin
          s_d.elapsed = inc_t(s_q.elapsed);
        end
        if (fall && s_q.out) s_d.elapsed = '0;
        if (!in_now && s_q.out && !rise &&
            (s_d.elapsed >= s_d.dur)) begin
          s_d.out     = 1'b0;
          s_d.elapsed = '0;
        end
        s_d.trig = !is_zero(s_d.elapsed);
      end
      default: begin
        // off, or an unused code: everything idles
        s_d.out     = 1'b0;
        s_d.trig    = 1'b0;
        s_d.elapsed = '0;
        s_d.shot_ld = 1'b0;
        s_d.rem     = s_d.dur;
      end
    endcase

    // in pulse and shot modes the live value is what is shown as time;
    // every other mode shows the duration through the same register,
    // so the time output needs no mux after the flops
    // limitation: after a type change the shown value follows one
    // clock later, which is far below one tick
    if (TYPE_SEL != CMT_PULSE && TYPE_SEL != CMT_SHOT) begin
      s_d.rem = s_d.dur;
    end
  end

  // state register; async reset to constants only
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flip-flops
  assign TIMER_OUT      = s_q.out;
  assign TRIGGERED_FLAG = s_q.trig;
  assign ELAPSED_TIME   = s_q.elapsed;
  assign TIME_VALUE     = s_q.rem;

endmodule // cmt_timer

// ==== cmt_timer_properties.sv ====
/* port checker for cmt_timer, bound into every instance.
   assumes a short TICK_CYCLES, 9 or more, in simulation. */
module cmt_timer_properties
  import cmt_pkg::*;
#(parameter int unsigned TICK_CYCLES = 10) (
  // clock and reset
  input wire logic      CLK_SYS,
  input wire logic      RST_N,
  // inputs watched
  input wire cmt_type_t TYPE_SEL,
  input wire cmt_time_t TIME_WDATA,
  input wire logic      TIME_WE,
  input wire logic      TRIG_IN,
  input wire logic      TRIG_NUM_SEL,
  input wire logic [15:0] TRIG_NUM,
  // outputs judged
  input wire logic      TIMER_OUT,
  input wire logic      TRIGGERED_FLAG,
  input wire cmt_time_t ELAPSED_TIME,
  input wire cmt_time_t TIME_VALUE
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // one-second step with carry into minutes
  function automatic cmt_time_t inc1(cmt_time_t t);
    return (t.sec == 6'h3b) ? {t.min + 10'h1, 6'h0} : {t.min, t.sec + 6'h1};
  endfunction
  // digital trigger edge, before the synchroniser
  sequence s_rise;
    !TRIG_NUM_SEL && $rose(TRIG_IN);
  endsequence
  a_off_clears: assert property (($past(TYPE_SEL) == CMT_OFF) |->
    !TIMER_OUT && !TRIGGERED_FLAG && ELAPSED_TIME == 16'h0)
    else $error("off type left output, flag or elapsed set");
  a_time_range: assert property (ELAPSED_TIME.sec <= 6'h3b &&
    ELAPSED_TIME.min <= 10'h3e7 && TIME_VALUE.sec <= 6'h3b)
    else $error("time value out of range");
  a_elapsed_step: assert property ($changed(ELAPSED_TIME) &&
    ELAPSED_TIME != 16'h0 |-> ELAPSED_TIME == inc1($past(ELAPSED_TIME)))
    else $error("elapsed moved by other than one second");
  a_tick_space: assert property ($changed(ELAPSED_TIME) &&
    ELAPSED_TIME != 16'h0 |=> ($stable(ELAPSED_TIME) ||
    ELAPSED_TIME == 16'h0)[*8]) else $error("elapsed stepped too soon");
  a_delay_cause: assert property ($rose(TIMER_OUT) &&
    TYPE_SEL == CMT_DELAY && !TRIG_NUM_SEL |-> $past(TRIG_IN, 3))
    else $error("delay output rose without trigger");
  a_pulse_rise: assert property (TYPE_SEL == CMT_PULSE ##0 s_rise
    |-> ##[2:4] TIMER_OUT) else $error("pulse output late");
  a_minon_rise: assert property (TYPE_SEL == CMT_MINON ##0 s_rise
    |-> ##[2:4] TIMER_OUT) else $error("minimum-on output late");
  a_shot_gate: assert property ((TYPE_SEL == CMT_SHOT &&
    !TRIG_NUM_SEL && !TRIG_IN)[*5] |-> !TIMER_OUT)
    else $error("shot output on with gate low");
  a_minon_flag: assert property ((TYPE_SEL == CMT_MINON &&
    ELAPSED_TIME != 16'h0)[*2] |-> TRIGGERED_FLAG)
    else $error("flag low while counting");
endmodule // cmt_timer_properties

bind cmt_timer cmt_timer_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .TYPE_SEL(TYPE_SEL),
  .TIME_WDATA(TIME_WDATA), .TIME_WE(TIME_WE), .TRIG_IN(TRIG_IN),
  .TRIG_NUM_SEL(TRIG_NUM_SEL), .TRIG_NUM(TRIG_NUM), .TIMER_OUT(TIMER_OUT),
  .TRIGGERED_FLAG(TRIGGERED_FLAG), .ELAPSED_TIME(ELAPSED_TIME),
  .TIME_VALUE(TIME_VALUE));

// ==== cmt_trig_src.sv ====
/* model of the controller logic wired to the trigger input.
   assumes the bench calls drive(); changes land on falling edges. */
module cmt_trig_src (
  input  wire logic   clk,
  output logic        trig_in,
  output logic        num_sel,
  output logic [15:0] num
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    trig_in = 1'b0;
    num_sel = 1'b0;
    num = 16'h0;
  end
  // numeric source: half and above reads as on
  task automatic drive(input logic s, input logic b, input logic [15:0] n);
    @(negedge clk);
    num_sel = s;
    trig_in = b;
    num = n;
  endtask
endmodule // cmt_trig_src

// ==== cmt_timer_tb.sv ====
/* self-checking bench for cmt_timer with a ten-cycle tick.
   assumes cmt_trig_src and the bound checker are compiled first. */
module cmt_timer_tb;
  import cmt_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK_SYS = 1'b0, RST_N = 1'b0, TIME_WE = 1'b0, t_in, n_sel, t_out, flg;
  cmt_type_t TYPE_SEL = CMT_OFF;
  cmt_time_t TIME_WDATA = 16'h0, el, tv;
  logic [15:0] t_num;
  int n_fail = 0, comparisons = 0;
  always #5 CLK_SYS = ~CLK_SYS;
  cmt_trig_src cmt_trig_src_inst (.clk(CLK_SYS), .trig_in(t_in),
    .num_sel(n_sel), .num(t_num));
  cmt_timer #(.TICK_CYCLES(10)) cmt_timer_inst (.CLK_SYS(CLK_SYS),
    .RST_N(RST_N), .TYPE_SEL(TYPE_SEL), .TIME_WDATA(TIME_WDATA),
    .TIME_WE(TIME_WE), .TRIG_IN(t_in), .TRIG_NUM_SEL(n_sel),
    .TRIG_NUM(t_num), .TIMER_OUT(t_out), .TRIGGERED_FLAG(flg),
    .ELAPSED_TIME(el), .TIME_VALUE(tv));
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic w(int n); repeat (n) @(negedge CLK_SYS); endtask
  task automatic wr(cmt_time_t t);
    @(negedge CLK_SYS);
    TIME_WDATA = t;
    TIME_WE = 1'b1;
    @(negedge CLK_SYS);
    TIME_WE = 1'b0;
  endtask
  task automatic tr(logic b); cmt_trig_src_inst.drive(1'b0, b, 16'h0); endtask
  task automatic end_sim;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic t_pulse;
    TYPE_SEL = CMT_PULSE;
    wr(16'h3);
    tr(1'b1);
    w(5);
    chk(t_out, 1'b1);
    chk(flg, 1'b1);
    w(15);
    tr(1'b0);
    w(2);
    tr(1'b1);
    w(21);
    chk(t_out, 1'b1);
    w(40);
    chk(t_out, 1'b0);
    chk(tv, 16'h0);
    tr(1'b0);
  endtask
  task automatic t_numeric;
    cmt_trig_src_inst.drive(1'b1, 1'b0, 16'h7fff);
    w(8);
    chk(t_out, 1'b0);
    cmt_trig_src_inst.drive(1'b1, 1'b0, 16'h8000);
    w(5);
    chk(t_out, 1'b1);
    cmt_trig_src_inst.drive(1'b0, 1'b0, 16'h0);
    w(40);
  endtask
  task automatic t_delay;
    TYPE_SEL = CMT_DELAY;
    wr(16'h2);
    tr(1'b1);
    w(5);
    tr(1'b0);
    w(40);
    chk(t_out, 1'b0);
    tr(1'b1);
    w(5);
    chk(t_out, 1'b0);
    w(30);
    chk(t_out, 1'b1);
    chk(tv, 16'h2);
    tr(1'b0);
    w(5);
    chk(t_out, 1'b0);
  endtask
  task automatic t_shot;
    TYPE_SEL = CMT_SHOT;
    wr(16'h2);
    w(2);
    chk(flg, 1'b1);
    w(30);
    chk(tv, 16'h2);
    tr(1'b1);
    w(5);
    chk(t_out, 1'b1);
    wr(16'h5);
    w(30);
    chk(t_out, 1'b1);
    w(40);
    chk(t_out, 1'b0);
    chk(flg, 1'b0);
    w(30);
    chk(tv, 16'h0);
    tr(1'b0);
  endtask
  task automatic t_minon;
    TYPE_SEL = CMT_MINON;
    wr(16'h3);
    tr(1'b1);
    w(5);
    chk(t_out, 1'b1);
    tr(1'b0);
    w(16);
    chk(flg, 1'b1);
    chk(t_out, 1'b1);
    tr(1'b1);
    w(5);
    chk(el, 16'h0);
    tr(1'b0);
    w(45);
    chk(t_out, 1'b0);
  endtask
  task automatic t_off;
    tr(1'b1);
    w(5);
    tr(1'b0);
    w(16);
    TYPE_SEL = CMT_OFF;
    w(2);
    chk({t_out, flg, el}, 18'h0);
    TYPE_SEL = CMT_DELAY;
    wr(16'hffff);
    chk(tv, {10'h3e7, 6'h3b});
  endtask
  initial begin
    w(12);
    RST_N = 1'b1;
    chk({t_out, flg, el, tv}, 34'h0);
    t_pulse();
    t_numeric();
    t_delay();
    t_shot();
    t_minon();
    t_off();
    end_sim();
  end
  initial begin
    #20000;
    n_fail++;
    end_sim();
  end
endmodule // cmt_timer_tb
